// [logic/rtc_top.sv]
// refresh timer controller with an axi4-lite register slave
`timescale 1ns/10ps

// How it works
// - two select bits choose timer, dram, psram
// - self-refresh in standby only when selected
// - match flag clears by read-one, write-zero
// - count equals constant: set flag, clear count
module rtc_top #(
  parameter int ADDR_W = 10
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby_req,
  output logic self_refresh_req,
  output rtc_pkg::rtc_mode_type memory_mode,
  output logic refresh_cycle_enable,
  output logic refresh_pin_output_enable,
  output logic column_width_select,
  output logic cas_strobe_select,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] refresh_control;
  logic compare_match_flag;
  logic compare_match_irq_enable;
  logic [2:0] prescale_select;
  logic [7:0] refresh_timer_count;
  logic [7:0] refresh_time_constant;
  logic irq_status;
  logic irq_mask;
  logic flag_seen_set;
  logic tick;
  logic match_event;
  logic aw_held;
  logic w_held;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic next_aw_held;
  logic next_w_held;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  rtc_prescaler #(
    .WIDTH(rtc_pkg::PRESCALE_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .select(prescale_select),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // axi4-lite write channels
  // ---------------------------------------------------------------
  // address and data are taken in either order; the write happens once both are held
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign next_aw_held = wr_fire ? 1'b0 : (aw_held || (s_axi_awvalid && s_axi_awready));
  assign next_w_held = wr_fire ? 1'b0 : (w_held || (s_axi_wvalid && s_axi_wready));

  // hold the address until the write is done
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      aw_held <= next_aw_held;
      s_axi_awready <= !next_aw_held;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_idx <= s_axi_awaddr[9:2];
      end
    end
  end

  // hold the data; only the low byte lane carries register bits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else begin
      w_held <= next_w_held;
      s_axi_wready <= !next_w_held;
      if (s_axi_wvalid && s_axi_wready) begin
        wr_byte <= s_axi_wdata[7:0];
        wr_lane <= s_axi_wstrb[0];
      end
    end
  end

  assign wr_hit = (wr_idx == rtc_pkg::IDX_REFRESH_CONTROL) || (wr_idx == rtc_pkg::IDX_TIMER_CSR) ||
                  (wr_idx == rtc_pkg::IDX_TIMER_COUNT) || (wr_idx == rtc_pkg::IDX_TIME_CONSTANT) ||
                  (wr_idx == rtc_pkg::IDX_IRQ_STATUS) || (wr_idx == rtc_pkg::IDX_IRQ_MASK);

  // write response one cycle after both halves are in
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rtc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channels
  // ---------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[9:2];

  // read data mux; fixed bits read as one, unused upper bits as zero
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      rtc_pkg::IDX_REFRESH_CONTROL: rd_byte = refresh_control | rtc_pkg::CONTROL_FIXED_ONES;
      rtc_pkg::IDX_TIMER_CSR: rd_byte = {compare_match_flag, compare_match_irq_enable, prescale_select, 3'h0} |
                                        rtc_pkg::CSR_FIXED_ONES;
      rtc_pkg::IDX_TIMER_COUNT: rd_byte = refresh_timer_count;
      rtc_pkg::IDX_TIME_CONSTANT: rd_byte = refresh_time_constant;
      rtc_pkg::IDX_IRQ_STATUS: rd_byte = {7'h00, irq_status};
      rtc_pkg::IDX_IRQ_MASK: rd_byte = {7'h00, irq_mask};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read at a time; arready drops while the answer waits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= rtc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_DECERR;
    end else begin
      s_axi_arready <= !s_axi_rvalid || s_axi_rready;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // refresh_control; bit 1 is fixed and not stored as a choice
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      refresh_control <= rtc_pkg::CONTROL_RESET;
    end else if (wr_fire && wr_lane && wr_idx == rtc_pkg::IDX_REFRESH_CONTROL) begin
      refresh_control <= wr_byte | rtc_pkg::CONTROL_FIXED_ONES;
    end
  end

  // enable, clock select, constant and mask
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      compare_match_irq_enable <= 1'b0;
      prescale_select <= 3'h0;
      refresh_time_constant <= rtc_pkg::CONSTANT_RESET;
      irq_mask <= 1'b0;
    end else if (wr_fire && wr_lane) begin
      if (wr_idx == rtc_pkg::IDX_TIMER_CSR) begin
        compare_match_irq_enable <= wr_byte[rtc_pkg::BIT_MATCH_IRQ_ENABLE];
        prescale_select <= wr_byte[rtc_pkg::POS_PRESCALE_SELECT +: 3];
      end
      if (wr_idx == rtc_pkg::IDX_TIME_CONSTANT) begin
        refresh_time_constant <= wr_byte;
      end
      if (wr_idx == rtc_pkg::IDX_IRQ_MASK) begin
        irq_mask <= wr_byte[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // refresh timer counter
  // ---------------------------------------------------------------
  // the match is acted on at a tick, so the count shows the constant for one whole period
  assign match_event = tick && (refresh_timer_count == refresh_time_constant);

  // software write wins over counting
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      refresh_timer_count <= rtc_pkg::COUNT_RESET;
    end else if (wr_fire && wr_lane && wr_idx == rtc_pkg::IDX_TIMER_COUNT) begin
      refresh_timer_count <= wr_byte;
    end else if (match_event) begin
      refresh_timer_count <= 8'h00;
    end else if (tick) begin
      refresh_timer_count <= refresh_timer_count + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // compare match flag and interrupt status
  // ---------------------------------------------------------------
  // arm the clear only after software has seen the flag as one
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flag_seen_set <= 1'b0;
    end else if (rd_fire && rd_idx == rtc_pkg::IDX_TIMER_CSR && compare_match_flag) begin
      flag_seen_set <= 1'b1;
    end else if (!compare_match_flag) begin
      flag_seen_set <= 1'b0;
    end
  end

  // a match in the clearing cycle keeps the flag set; writing one does nothing
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      compare_match_flag <= 1'b0;
    end else if (match_event) begin
      compare_match_flag <= 1'b1;
    end else if (wr_fire && wr_lane && wr_idx == rtc_pkg::IDX_TIMER_CSR && flag_seen_set &&
                 !wr_byte[rtc_pkg::BIT_MATCH_FLAG]) begin
      compare_match_flag <= 1'b0;
    end
  end

  // sticky event bit, write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq_status <= 1'b0;
    end else if (match_event) begin
      irq_status <= 1'b1;
    end else if (wr_fire && wr_lane && wr_idx == rtc_pkg::IDX_IRQ_STATUS && wr_byte[0]) begin
      irq_status <= 1'b0;
    end
  end

  // level interrupt from either the flag with its enable or the masked sticky bit
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (compare_match_flag && compare_match_irq_enable) || (irq_status && irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // memory side outputs
  // ---------------------------------------------------------------
  // an illegal selection requests no self-refresh; the other control copies still follow their bits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      memory_mode <= rtc_pkg::RTC_MODE_TIMER;
      self_refresh_req <= 1'b0;
      refresh_cycle_enable <= 1'b0;
      refresh_pin_output_enable <= 1'b0;
      column_width_select <= 1'b0;
      cas_strobe_select <= 1'b0;
    end else begin
      unique case ({refresh_control[rtc_pkg::BIT_PSEUDO_STATIC], refresh_control[rtc_pkg::BIT_DYNAMIC_MEMORY]})
        2'h0: memory_mode <= rtc_pkg::RTC_MODE_TIMER;
        2'h1: memory_mode <= rtc_pkg::RTC_MODE_DYNAMIC;
        2'h2: memory_mode <= rtc_pkg::RTC_MODE_PSEUDO;
        2'h3: memory_mode <= rtc_pkg::RTC_MODE_ILLEGAL;
      endcase
      self_refresh_req <= refresh_control[rtc_pkg::BIT_SELF_REFRESH] && standby_req &&
                          (refresh_control[rtc_pkg::BIT_PSEUDO_STATIC] ^ refresh_control[rtc_pkg::BIT_DYNAMIC_MEMORY]);
      refresh_cycle_enable <= refresh_control[rtc_pkg::BIT_REFRESH_CYCLE];
      refresh_pin_output_enable <= refresh_control[rtc_pkg::BIT_REFRESH_PIN];
      column_width_select <= refresh_control[rtc_pkg::BIT_COLUMN_WIDTH];
      cas_strobe_select <= refresh_control[rtc_pkg::BIT_CAS_STROBE];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence seq_read_one;
    rd_fire && rd_idx == rtc_pkg::IDX_TIMER_CSR && compare_match_flag;
  endsequence
  chk_mode_decode: assert property (
    ##1 memory_mode == (&{$past(refresh_control[6]), $past(refresh_control[5])} ? rtc_pkg::RTC_MODE_ILLEGAL :
        $past(refresh_control[6]) ? rtc_pkg::RTC_MODE_PSEUDO :
        $past(refresh_control[5]) ? rtc_pkg::RTC_MODE_DYNAMIC : rtc_pkg::RTC_MODE_TIMER))
    else $error("memory mode does not follow the select bits");
  chk_self_refresh_gate: assert property (
    self_refresh_req |-> $past(standby_req && refresh_control[7] && (refresh_control[6] ^ refresh_control[5])))
    else $error("self refresh requested without standby and selection");
  chk_flag_clear_armed: assert property (
    $fell(compare_match_flag) |-> $past(flag_seen_set) && $past(wr_fire) && !$past(wr_byte[7]))
    else $error("match flag cleared without read-one then write-zero");
  chk_flag_arms: assert property (seq_read_one |=> flag_seen_set)
    else $error("read of the set flag did not arm the clear");
  chk_flag_needs_read: assert property (
    compare_match_flag && !flag_seen_set |=> compare_match_flag)
    else $error("match flag lost before being read as one");
  chk_match_clears: assert property (
    match_event && !(wr_fire && wr_idx == rtc_pkg::IDX_TIMER_COUNT) |=> refresh_timer_count == 8'h00 &&
                                                                        compare_match_flag)
    else $error("match did not clear count and set flag");
  chk_count_step: assert property (
    tick && !match_event && !wr_fire |=> refresh_timer_count == $past(refresh_timer_count) + 8'h01)
    else $error("count did not advance on a tick");
  chk_count_hold: assert property (
    prescale_select == 3'h0 && !wr_fire [*3] |=> $stable(refresh_timer_count))
    else $error("count moved with its clock disabled");
  chk_write_answer: assert property (
    (wr_fire |=> s_axi_bvalid) and (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response missing or not held");

endmodule

// [logic/rtc_pkg.sv]
// constants of the refresh timer controller: register indices, fields, reset values
package rtc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_REFRESH_CONTROL = 8'hac;
  localparam logic [7:0] IDX_TIMER_CSR = 8'had;
  localparam logic [7:0] IDX_TIMER_COUNT = 8'hae;
  localparam logic [7:0] IDX_TIME_CONSTANT = 8'haf;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hb0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hb1;

  // ---------------------------------------------------------------
  // refresh_control fields
  // ---------------------------------------------------------------
  localparam int BIT_SELF_REFRESH = 7;
  localparam int BIT_PSEUDO_STATIC = 6;
  localparam int BIT_DYNAMIC_MEMORY = 5;
  localparam int BIT_CAS_STROBE = 4;
  localparam int BIT_COLUMN_WIDTH = 3;
  localparam int BIT_REFRESH_PIN = 2;
  localparam int BIT_REFRESH_CYCLE = 0;
  localparam logic [7:0] CONTROL_FIXED_ONES = 8'h02;
  localparam logic [7:0] CONTROL_RESET = 8'h02;

  // ---------------------------------------------------------------
  // refresh_timer_control_status fields
  // ---------------------------------------------------------------
  localparam int BIT_MATCH_FLAG = 7;
  localparam int BIT_MATCH_IRQ_ENABLE = 6;
  localparam int POS_PRESCALE_SELECT = 3;
  localparam logic [7:0] CSR_FIXED_ONES = 8'h07;

  // ---------------------------------------------------------------
  // reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CONSTANT_RESET = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ---------------------------------------------------------------
  // prescaler: divide ratios are powers of two, selected by log2
  // ---------------------------------------------------------------
  localparam int PRESCALE_W = 12;
  typedef logic [3:0] rtc_log2_type;
  localparam rtc_log2_type PRESCALE_LOG2 [8] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'hc};

  // ---------------------------------------------------------------
  // memory interface selection
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RTC_MODE_TIMER,
    RTC_MODE_DYNAMIC,
    RTC_MODE_PSEUDO,
    RTC_MODE_ILLEGAL
  } rtc_mode_type;

endpackage

// [logic/rtc_prescaler.sv]
// prescaler that turns the system clock into the selected counting tick
`timescale 1ns/10ps
module rtc_prescaler #(
  parameter int WIDTH = rtc_pkg::PRESCALE_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] select,
  output logic tick
);

  logic [WIDTH-1:0] div_count;
  logic [WIDTH-1:0] low_mask;

  // free running divider; every ratio taps the same chain so a change of select is glitch free
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  // mask of the low bits that must all be one at the end of a period
  always_comb begin
    low_mask = (WIDTH'(1) << rtc_pkg::PRESCALE_LOG2[select]) - WIDTH'(1);
  end

  // a zero select gives no tick at all, so the counter holds
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tick <= 1'b0;
    end else begin
      tick <= (select != 3'h0) && ((div_count & low_mask) == low_mask);
    end
  end

endmodule

// [verif/rtc_memory_model.sv]
// behavioural model of the external memory that the controller keeps in self-refresh
`timescale 1ns/10ps
module rtc_memory_model (
  input wire logic clk_sys,
  input wire logic self_refresh_req,
  input wire rtc_pkg::rtc_mode_type memory_mode,
  output logic in_self_refresh,
  output logic bad_req
);
  logic stray;
  logic stray_d;

  // a request with no memory attached is stray; one cycle of skew between the two lines is forgiven
  assign stray = self_refresh_req && !(memory_mode == rtc_pkg::RTC_MODE_DYNAMIC ||
    memory_mode == rtc_pkg::RTC_MODE_PSEUDO);
  initial in_self_refresh = 1'b0;
  initial bad_req = 1'b0;
  initial stray_d = 1'b0;

  // the memory refreshes itself while asked to, whatever it costs
  always @(posedge clk_sys) begin
    in_self_refresh <= self_refresh_req;
    stray_d <= stray;
    bad_req <= bad_req | (stray & stray_d);
  end
endmodule

// [verif/refresh_timer_control_tb.sv]
// self-checking bench of the refresh timer controller
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module refresh_timer_control_tb;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam logic [7:0] CTL = rtc_pkg::IDX_REFRESH_CONTROL;
  localparam logic [7:0] CSR = rtc_pkg::IDX_TIMER_CSR;
  localparam logic [7:0] CNT = rtc_pkg::IDX_TIMER_COUNT;
  localparam logic [7:0] COR = rtc_pkg::IDX_TIME_CONSTANT;
  localparam logic [7:0] STA = rtc_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] MSK = rtc_pkg::IDX_IRQ_MASK;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, standby = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, srf_req, rcyc, rpin, colw, casw, irq, in_srf, bad_req;
  logic [1:0] bresp, rresp, eb;
  logic [31:0] rdata;
  logic [65:0] er;
  logic [7:0] q, c;
  rtc_pkg::rtc_mode_type mode;
  logic [1:0] exp_b [$];
  logic [65:0] exp_r [$];
  int error_cnt = 0, check_count = 0, cyc = 0, seed = 54714, n, t0;
  int div [8] = '{0, 2, 8, 32, 128, 512, 2048, 4096};

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  rtc_top dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .standby_req(standby),
    .self_refresh_req(srf_req), .memory_mode(mode), .refresh_cycle_enable(rcyc),
    .refresh_pin_output_enable(rpin), .column_width_select(colw), .cas_strobe_select(casw), .irq(irq)
  );
  rtc_memory_model mem_u (
    .clk_sys(clk_sys), .self_refresh_req(srf_req), .memory_mode(mode), .in_self_refresh(in_srf),
    .bad_req(bad_req)
  );

  // scoreboard: every bus answer takes the oldest note
  always @(posedge clk_sys) begin
    if (bvalid && bready) begin
      eb = exp_b.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready) begin
      er = exp_r.pop_front();
      `CHK("rresp", er[65:64], rresp)
      `CHK("rdata", er[31:0], rdata & er[63:32])
    end
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic expire(input int k, input int lim);
    if (k >= lim) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  // ready is raised at random, but no later than one cycle after the answer, so stalls stay short
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rsp = rtc_pkg::RESP_OKAY);
    int k;
    logic a, w;
    k = 0;
    a = 1'b0;
    w = 1'b0;
    exp_b.push_back(rsp);
    awaddr <= {idx, 2'b00};
    wdata <= {24'($random(seed)), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (k < 300) begin
      @(posedge clk_sys);
      k++;
      if (bvalid && bready) break;
      a = a | (awvalid & awready);
      w = w | (wvalid & wready);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      bready <= bready | (a & w & (bvalid | 1'($random(seed))));
    end
    bready <= 1'b0;
    expire(k, 300);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, output logic [7:0] d,
                    input logic [7:0] m = 8'hff, input logic [1:0] rsp = rtc_pkg::RESP_OKAY);
    int k;
    k = 0;
    exp_r.push_back({rsp, 24'hffffff, m, 24'h0, ex & m});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    while (k < 300) begin
      @(posedge clk_sys);
      k++;
      if (rvalid && rready) break;
      arvalid <= arvalid & ~arready;
      rready <= rready | (~arvalid & (rvalid | 1'($random(seed))));
    end
    d = rdata[7:0];
    rready <= 1'b0;
    expire(k, 300);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(CTL, 8'h02, q);
    rd(CSR, 8'h07, q);
    rd(CNT, 8'h00, q);
    rd(COR, 8'hff, q);
    rd(STA, 8'h00, q);
    rd(MSK, 8'h00, q);
    `CHK("irq", 1'b0, irq)
    // a one written to the clear flag must not set it
    wr(CSR, 8'h80);
    rd(CSR, 8'h07, q);
    // each memory selection, self-refresh asked for while in standby
    standby <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(CTL, {1'b1, 2'(i), 5'h1d});
      repeat (2) @(posedge clk_sys);
      `CHK("memory_mode", 2'(i), mode)
      `CHK("self_refresh_req", 1'(i == 1 || i == 2), srf_req)
      `CHK("in_self_refresh", 1'(i == 1 || i == 2), in_srf)
      `CHK("control copies", 4'hf, {casw, colw, rpin, rcyc})
      rd(CTL, {1'b1, 2'(i), 5'h1f}, q);
    end
    wr(CTL, 8'h20);
    repeat (2) @(posedge clk_sys);
    `CHK("self_refresh_req off", 1'b0, srf_req)
    `CHK("control copies", 4'h0, {casw, colw, rpin, rcyc})
    wr(CTL, 8'ha0);
    standby <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("self_refresh_req awake", 1'b0, srf_req)
    // stopped source holds the count
    wr(CSR, 8'h00);
    wr(CNT, 8'h05);
    repeat (40) @(posedge clk_sys);
    rd(CNT, 8'h05, q);
    // every divider: ticks counted against measured elapsed cycles
    for (int s = 1; s < 8; s++) begin
      wr(COR, 8'hff);
      wr(CSR, {2'b00, 3'(s), 3'b000});
      wr(CNT, 8'h00);
      t0 = cyc;
      repeat (3 * div[s]) @(posedge clk_sys);
      rd(CNT, 8'h00, q, 8'h00);
      n = cyc - t0;
      `CHK("ticks", 1'b1, 1'(q >= (n - 2) / div[s] && q <= (n + 3) / div[s] + 1))
    end
    // match after constant plus one ticks, then count restarts from zero
    c = 8'h08 + 8'($random(seed) & 31);
    wr(CSR, 8'h08);
    wr(COR, c);
    wr(CNT, 8'h00);
    t0 = cyc;
    q = 8'h00;
    n = 0;
    while (!q[7] && n < 100) begin
      rd(CSR, 8'h00, q, 8'h00);
      n++;
    end
    expire(n, 100);
    n = cyc - t0;
    `CHK("match time", 1'b1, 1'(n >= 2 * c - 2 && n <= 2 * c + 12))
    wr(CSR, 8'h80);
    rd(CNT, 8'h00, q, 8'h00);
    `CHK("count cleared", 1'b1, 1'(q < 8'h08))
    rd(CSR, 8'h87, q);
    wr(CSR, 8'h00);
    rd(CSR, 8'h07, q);
    // sticky status, mask and write-one clear
    rd(STA, 8'h01, q);
    `CHK("irq masked", 1'b0, irq)
    wr(MSK, 8'h01);
    repeat (2) @(posedge clk_sys);
    `CHK("irq unmasked", 1'b1, irq)
    wr(STA, 8'h01);
    repeat (2) @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq)
    rd(STA, 8'h00, q);
    wr(MSK, 8'h00);
    // zero written without a prior read of the set flag leaves it set
    wr(COR, 8'h02);
    wr(CNT, 8'h00);
    wr(CSR, 8'h48);
    n = 0;
    while (!irq && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    expire(n, 200);
    wr(CSR, 8'h40);
    rd(CSR, 8'hc7, q);
    `CHK("irq held", 1'b1, irq)
    wr(CSR, 8'h40);
    rd(CSR, 8'h47, q);
    repeat (2) @(posedge clk_sys);
    `CHK("irq after flag clear", 1'b0, irq)
    // unmapped place answers with an error and reads zero
    wr(8'hff, 8'h55, rtc_pkg::RESP_DECERR);
    rd(8'hff, 8'h00, q, 8'hff, rtc_pkg::RESP_DECERR);
    // a write with the low byte lane off is answered but leaves the register alone
    wstrb <= 4'he;
    wr(COR, 8'h11);
    wstrb <= 4'hf;
    rd(COR, 8'h02, q);
    `CHK("stray self-refresh", 1'b0, bad_req)
    wrap_up();
  end
endmodule
